// *** src/scsc_top.sv ***
// Chosen here: the APB slave port.
`include "scsc_defines.svh"
`default_nettype none
module scsc_top
  import scsc_pkg::*;
#(
  parameter logic [23:0] WARM_00_CYC = `SCSC_WARM_00_CYC,  // warm-up code 00
  parameter logic [23:0] WARM_01_CYC = `SCSC_WARM_01_CYC,  // warm-up code 01
  parameter logic [23:0] WARM_10_CYC = `SCSC_WARM_10_CYC   // warm-up code 10
) (
  input  wire logic        pclk,                          // high-frequency clock
  input  wire logic        presetn,                       // hardware reset, active low
  input  wire logic        psel,                          // APB select
  input  wire logic        penable,                       // APB enable
  input  wire logic        pwrite,                        // APB direction
  input  wire logic [11:0] paddr,                         // APB byte address
  input  wire logic [31:0] pwdata,                        // APB write data
  output logic             pready,                        // APB ready
  output logic [31:0]      prdata,                        // APB read data
  output logic             pslverr,                       // APB error
  input  wire logic        wake_pin,                      // wake-up pin level
  input  wire logic        irq_peripheral,                // peripheral interrupt request
  input  wire logic        irq_external,                  // external interrupt request
  input  wire logic        interrupt_master_enable_flag,  // core interrupt enable
  output scsc_clk_ctl_t    clk_ctl,                       // clock gates, oscillator
  output scsc_src_clk_t    src_clk,                       // peripheral source ticks
  output logic             mcycle_pulse,                  // machine cycle tick
  output logic             port_hold,                     // ports keep latched values
  output logic             port_hiz,                      // ports float
  output logic             warm_up_active,                // warm-up running
  output logic             resume_next,                   // resume after wake, pulse
  output logic             service_irq,                   // service interrupt, pulse
  output logic             sys_reset_req,                 // oscillator off reset, pulse
  output scsc_mode_t       mode                           // current mode
);

  logic [7:0]   standby_mode_control;
  logic [7:0]   next_standby_mode_control;
  logic [7:0]   second_system_control;
  logic [7:0]   next_second_system_control;
  logic         divider_prescale_select;
  logic         next_divider_prescale_select;
  scsc_mode_t   next_mode;
  logic         edge_mode;
  logic         next_edge_mode;
  logic         wake_prev;
  logic         next_resume_next;
  logic         next_service_irq;
  logic         next_sys_reset_req;
  logic         next_port_hold;
  logic         next_port_hiz;
  logic [31:0]  next_prdata;
  logic         div_clear;
  logic         div_run;
  logic [23:0]  chain;
  logic [23:0]  warm_target;
  logic         warm_done;
  logic         wake_hit;
  logic         irq_any;
  logic         wr_en;
  logic         rd_setup;
  logic [9:0]   word_idx;
  logic         mapped;

  // ---------------- APB decode ----------------
  assign word_idx = paddr[11:2];
  assign mapped   = (word_idx == {2'h0, `SCSC_IDX_STANDBY})
                 || (word_idx == {2'h0, `SCSC_IDX_SYSCTL2})
                 || (word_idx == {2'h0, `SCSC_IDX_DIVCTL})
                 || (word_idx == {2'h0, `SCSC_IDX_STATUS});
  // zero wait: the slave answers in the first access cycle
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  // halted logic takes no register writes
  assign wr_en    = psel && penable && pwrite && mapped
                 && (mode != SCSC_HALT) && (mode != SCSC_WARMUP);
  assign rd_setup = psel && !penable && !pwrite;

  // read data is captured in the setup cycle so it comes from a flop
  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      next_prdata = 32'h0;
      case (word_idx)
        {2'h0, `SCSC_IDX_STANDBY}: begin
          // low bits read back as zero
          next_prdata[7:0] = {standby_mode_control[7:2], 2'h0};
        end
        {2'h0, `SCSC_IDX_SYSCTL2}: begin
          // clock select monitors the live selection; low nibble and bit 6 read zero
          next_prdata[7:0] = {second_system_control[`SCSC_SC2_OSC_RUN], 1'b0,
                              clk_ctl.sysclk_sel, second_system_control[`SCSC_SC2_IDLE],
                              4'h0};
        end
        {2'h0, `SCSC_IDX_DIVCTL}: begin
          next_prdata[0] = divider_prescale_select;
        end
        {2'h0, `SCSC_IDX_STATUS}: begin
          next_prdata[2:0] = {warm_up_active, mode};
        end
        default: begin
          next_prdata = 32'h0;
        end
      endcase
    end
  end

  // ---------------- timing generator ----------------
  // warm-up counts the zero-cleared chain
  // delay per code, doubled by prescale
  always_comb begin
    case (standby_mode_control[`SCSC_SMC_WARM_HI:`SCSC_SMC_WARM_LO])
      2'b00:   warm_target = WARM_00_CYC;
      2'b01:   warm_target = WARM_01_CYC;
      2'b10:   warm_target = WARM_10_CYC;
      // reserved code, treated as the longest delay
      default: warm_target = WARM_00_CYC;
    endcase
    if (divider_prescale_select) begin
      warm_target = {warm_target[22:0], 1'b0};
    end
  end

  assign warm_done = (mode == SCSC_WARMUP) && (chain == warm_target - 24'h000001);

  // clear on halt entry, exit and warm-up end
  assign div_clear = (next_mode != mode)
                  && ((next_mode == SCSC_HALT) || (next_mode == SCSC_WARMUP)
                   || (mode == SCSC_HALT) || warm_done);
  assign div_run   = (mode != SCSC_HALT);

  scsc_divider u_divider (
    .pclk         (pclk),
    .presetn      (presetn),
    .clear        (div_clear),
    .run          (div_run),
    .prescale_sel (divider_prescale_select),
    .chain        (chain),
    .mcycle_pulse (mcycle_pulse),
    .src          (src_clk)
  );

  // ---------------- standby control ----------------
  // level or rising edge per latched mode
  assign wake_hit = edge_mode ? (wake_pin && !wake_prev) : wake_pin;
  assign irq_any  = irq_peripheral || irq_external;

  always_comb begin
    next_mode                    = mode;
    next_edge_mode               = edge_mode;
    next_standby_mode_control    = standby_mode_control;
    next_second_system_control   = second_system_control;
    next_divider_prescale_select = divider_prescale_select;
    next_resume_next             = 1'b0;
    next_service_irq             = 1'b0;
    next_sys_reset_req           = 1'b0;

    if (wr_en) begin
      case (word_idx)
        {2'h0, `SCSC_IDX_STANDBY}: begin
          next_standby_mode_control = {pwdata[7:2], 2'h0};
        end
        {2'h0, `SCSC_IDX_SYSCTL2}: begin
          next_second_system_control = {pwdata[7], 1'b0, pwdata[5:4], 4'h0};
          next_sys_reset_req         = !pwdata[`SCSC_SC2_OSC_RUN];
        end
        {2'h0, `SCSC_IDX_DIVCTL}: begin
          next_divider_prescale_select = pwdata[`SCSC_DIV_PRESCALE];
        end
        default: begin
        end
      endcase
    end

    case (mode)
      SCSC_NORMAL: begin
        if (standby_mode_control[`SCSC_SMC_HALT]) begin
          next_edge_mode = !standby_mode_control[`SCSC_SMC_WAKE_SEL];
          if (standby_mode_control[`SCSC_SMC_WAKE_SEL] && wake_pin) begin
            // high pin in level mode skips the halt straight to warm-up
            next_mode = SCSC_WARMUP;
          end else begin
            next_mode = SCSC_HALT;
          end
        end else if (second_system_control[`SCSC_SC2_IDLE]) begin
          next_mode = SCSC_IDLE;
        end
      end
      SCSC_IDLE: begin
        if (irq_any) begin
          next_mode = SCSC_NORMAL;
          next_second_system_control[`SCSC_SC2_IDLE] = 1'b0;
          next_service_irq = interrupt_master_enable_flag;
          next_resume_next = !interrupt_master_enable_flag;
        end
      end
      SCSC_HALT: begin
        if (wake_hit) begin
          next_mode = SCSC_WARMUP;
        end
      end
      SCSC_WARMUP: begin
        // a low pin during warm-up does not return to halt
        if (warm_done) begin
          next_mode = SCSC_NORMAL;
          next_standby_mode_control[`SCSC_SMC_HALT] = 1'b0;
          next_second_system_control[`SCSC_SC2_OSC_RUN] =
            !standby_mode_control[`SCSC_SMC_POST_WAKE];
          next_second_system_control[`SCSC_SC2_CLK_SEL] =
            standby_mode_control[`SCSC_SMC_POST_WAKE];
          next_resume_next = 1'b1;
        end
      end
      default: begin
        next_mode = SCSC_NORMAL;
      end
    endcase
  end

  // ports hold or float while halted
  always_comb begin
    next_port_hold = 1'b0;
    next_port_hiz  = 1'b0;
    if ((next_mode == SCSC_HALT) || (next_mode == SCSC_WARMUP)) begin
      next_port_hold = standby_mode_control[`SCSC_SMC_HOLD];
      next_port_hiz  = !standby_mode_control[`SCSC_SMC_HOLD];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode                    <= SCSC_NORMAL;
      edge_mode               <= 1'b0;
      wake_prev               <= 1'b0;
      standby_mode_control    <= `SCSC_SMC_RESET;
      second_system_control   <= `SCSC_SC2_RESET;
      divider_prescale_select <= 1'b0;
      resume_next             <= 1'b0;
      service_irq             <= 1'b0;
      sys_reset_req           <= 1'b0;
      port_hold               <= 1'b0;
      port_hiz                <= 1'b0;
      prdata                  <= 32'h0;
    end else begin
      mode                    <= next_mode;
      edge_mode               <= next_edge_mode;
      wake_prev               <= wake_pin;
      standby_mode_control    <= next_standby_mode_control;
      second_system_control   <= next_second_system_control;
      divider_prescale_select <= next_divider_prescale_select;
      resume_next             <= next_resume_next;
      service_irq             <= next_service_irq;
      sys_reset_req           <= next_sys_reset_req;
      port_hold               <= next_port_hold;
      port_hiz                <= next_port_hiz;
      prdata                  <= next_prdata;
    end
  end

  // idle gates CPU and watchdog only
  // halt stops oscillator and all clocks
  assign clk_ctl.osc_enable      = (mode != SCSC_HALT)
                                && second_system_control[`SCSC_SC2_OSC_RUN];
  assign clk_ctl.sysclk_sel      = second_system_control[`SCSC_SC2_CLK_SEL];
  assign clk_ctl.cpu_clk_en      = (mode == SCSC_NORMAL);
  assign clk_ctl.watchdog_clk_en = (mode == SCSC_NORMAL);
  assign clk_ctl.periph_clk_en   = (mode == SCSC_NORMAL) || (mode == SCSC_IDLE);
  assign warm_up_active          = (mode == SCSC_WARMUP);

endmodule // scsc_top
`default_nettype wire

// *** src/scsc_defines.svh ***
`ifndef SCSC_DEFINES_SVH
`define SCSC_DEFINES_SVH

// register indices; byte address is four times the index
`define SCSC_IDX_STANDBY    8'h38
`define SCSC_IDX_SYSCTL2    8'h39
`define SCSC_IDX_DIVCTL     8'h3a
`define SCSC_IDX_STATUS     8'h3b

// standby_mode_control fields
`define SCSC_SMC_HALT       7
`define SCSC_SMC_WAKE_SEL   6
`define SCSC_SMC_POST_WAKE  5
`define SCSC_SMC_HOLD       4
`define SCSC_SMC_WARM_HI    3
`define SCSC_SMC_WARM_LO    2
`define SCSC_SMC_RESET      8'h00

// second_system_control fields
`define SCSC_SC2_OSC_RUN    7
`define SCSC_SC2_CLK_SEL    5
`define SCSC_SC2_IDLE       4
`define SCSC_SC2_RESET      8'h80

// divider control field
`define SCSC_DIV_PRESCALE   0
`define SCSC_DIV_RESET      8'h00

// timing generator shape
`define SCSC_PRESCALE_BITS  3
`define SCSC_DIVIDER_BITS   21
`define SCSC_CHAIN_BITS     24
`define SCSC_MCYCLE_FC      4

// source clock taps into the chain (divide by two to the tap)
`define SCSC_TAP_DIVOUT     13
`define SCSC_TAP_TIMEBASE   15
`define SCSC_TAP_WATCHDOG   17
`define SCSC_TAP_TIMER      7

// warm-up lengths in high-frequency clock periods, prescale off
`define SCSC_WARM_00_CYC    24'd196608
`define SCSC_WARM_01_CYC    24'd65536
`define SCSC_WARM_10_CYC    24'd16384

`endif

// *** src/scsc_pkg.sv ***
`default_nettype none
package scsc_pkg;

  typedef enum logic [1:0] {
    SCSC_NORMAL = 2'b00,
    SCSC_IDLE   = 2'b01,
    SCSC_HALT   = 2'b10,
    SCSC_WARMUP = 2'b11
  } scsc_mode_t;

  // one-cycle ticks of the peripheral source clocks
  typedef struct packed {
    logic divider_output_pulse;
    logic timebase_tick;
    logic watchdog_tick;
    logic timer_tick;
  } scsc_src_clk_t;

  // clock gates and oscillator control toward the core
  typedef struct packed {
    logic osc_enable;
    logic sysclk_sel;
    logic cpu_clk_en;
    logic watchdog_clk_en;
    logic periph_clk_en;
  } scsc_clk_ctl_t;

endpackage : scsc_pkg
`default_nettype wire

// *** src/scsc_divider.sv ***
`include "scsc_defines.svh"
`default_nettype none
module scsc_divider
  import scsc_pkg::*;
(
  input  wire logic                        pclk,          // high-frequency clock
  input  wire logic                        presetn,       // async reset, active low
  input  wire logic                        clear,         // zero prescaler and dividers
  input  wire logic                        run,           // low while oscillator halted
  input  wire logic                        prescale_sel,  // divider prescale select
  output logic [`SCSC_CHAIN_BITS-1:0]      chain,         // prescaler plus divider value
  output logic                             mcycle_pulse,  // one per machine cycle
  output scsc_src_clk_t                    src            // source clock ticks
);

  localparam int NTAP = 4;
  localparam int TAPS [NTAP] = '{`SCSC_TAP_DIVOUT, `SCSC_TAP_TIMEBASE,
                                 `SCSC_TAP_WATCHDOG, `SCSC_TAP_TIMER};

  logic [`SCSC_CHAIN_BITS-1:0] next_chain;
  logic [1:0]                  mcycle;
  logic [1:0]                  next_mcycle;
  logic [NTAP-1:0]             tick;
  logic [NTAP-1:0]             next_tick;
  logic                        next_mcycle_pulse;

  // cleared on reset, on halt entry and exit, and at warm-up end
  always_comb begin
    next_chain        = chain;
    next_mcycle       = mcycle;
    next_mcycle_pulse = 1'b0;
    if (clear) begin
      next_chain  = '0;
      next_mcycle = 2'h0;
    end else if (run) begin
      next_chain        = chain + 24'h000001;
      next_mcycle       = mcycle + 2'h1;
      next_mcycle_pulse = (mcycle == 2'(`SCSC_MCYCLE_FC - 1));
    end
  end

  generate
    for (genvar i = 0; i < NTAP; i++) begin : g_tap
      localparam int T = TAPS[i];
      always_comb begin
        if (prescale_sel) begin
          next_tick[i] = run && !clear && (&chain[T:0]);
        end else begin
          next_tick[i] = run && !clear && (&chain[T-1:0]);
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain        <= '0;
      mcycle       <= 2'h0;
      mcycle_pulse <= 1'b0;
      tick         <= '0;
    end else begin
      chain        <= next_chain;
      mcycle       <= next_mcycle;
      mcycle_pulse <= next_mcycle_pulse;
      tick         <= next_tick;
    end
  end

  assign src.divider_output_pulse = tick[0];
  assign src.timebase_tick        = tick[1];
  assign src.watchdog_tick        = tick[2];
  assign src.timer_tick           = tick[3];

endmodule // scsc_divider
`default_nettype wire

// *** test/scsc_top_asserts.sv ***
`default_nettype none
module scsc_top_asserts
  import scsc_pkg::*;
#(
  parameter logic [23:0] WARM_00_CYC = 24'd48, // warm-up code 00
  parameter logic [23:0] WARM_01_CYC = 24'd16, // warm-up code 01
  parameter logic [23:0] WARM_10_CYC = 24'd8   // warm-up code 10
) (
  input wire logic          pclk,                         // clock
  input wire logic          presetn,                      // reset, active low
  input wire logic          psel,                         // select
  input wire logic          penable,                      // enable
  input wire logic          pwrite,                       // direction
  input wire logic [11:0]   paddr,                        // address
  input wire logic [31:0]   pwdata,                       // write data
  input wire logic          irq_peripheral,               // peripheral request
  input wire logic          irq_external,                 // external request
  input wire logic          interrupt_master_enable_flag, // master enable
  input wire scsc_clk_ctl_t clk_ctl,                      // clock gates
  input wire scsc_src_clk_t src_clk,                      // source ticks
  input wire logic          mcycle_pulse,                 // machine cycle
  input wire logic          port_hold,                    // ports held
  input wire logic          port_hiz,                     // ports float
  input wire logic          resume_next,                  // resume pulse
  input wire logic          service_irq,                  // service pulse
  input wire scsc_mode_t    mode                          // mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [24:0] wcnt;
  logic [24:0] next_wcnt;
  logic        irq_any;
  assign irq_any = irq_peripheral || irq_external;
  always_comb next_wcnt = (mode == SCSC_WARMUP) ? wcnt + 25'd1 : 25'd0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wcnt <= 25'd0;
    else wcnt <= next_wcnt;
  end
  a_reset_normal: assert property ($rose(presetn) |-> mode == SCSC_NORMAL)
    else $error("mode not normal after reset");
  a_mcycle_four: assert property (mcycle_pulse |=> !mcycle_pulse [*3])
    else $error("machine cycle shorter than four clocks");
  a_idle_gates: assert property (mode == SCSC_IDLE |-> !clk_ctl.cpu_clk_en
    && !clk_ctl.watchdog_clk_en && clk_ctl.periph_clk_en) else $error("idle gating wrong");
  a_idle_wake: assert property (mode == SCSC_IDLE && irq_any |=> mode == SCSC_NORMAL)
    else $error("interrupt did not end idle");
  a_irq_service: assert property (mode == SCSC_IDLE && irq_any && interrupt_master_enable_flag
    |=> service_irq && !resume_next) else $error("interrupt not serviced");
  a_irq_resume: assert property (mode == SCSC_IDLE && irq_any && !interrupt_master_enable_flag
    |=> resume_next && !service_irq) else $error("no resume after idle");
  a_halt_quiet: assert property ($past(mode) == SCSC_HALT && mode == SCSC_HALT
    |-> !clk_ctl.osc_enable && !mcycle_pulse && src_clk == '0) else $error("halt not quiet");
  a_port_state: assert property ($past(mode) == SCSC_HALT && mode == SCSC_HALT
    |-> port_hold != port_hiz) else $error("port state in halt wrong");
  a_warm_bound: assert property (wcnt <= {WARM_00_CYC, 1'b0})
    else $error("warm-up too long");
  a_warm_resume: assert property (mode == SCSC_WARMUP ##1 mode == SCSC_NORMAL
    |-> ##[0:1] resume_next) else $error("no resume after warm-up");
  a_halt_entry: assert property (psel && penable && pwrite && paddr == 12'h0e0 && pwdata[7]
    && mode == SCSC_NORMAL |=> ##1 mode inside {SCSC_HALT, SCSC_WARMUP})
    else $error("halt missed");
  c_idle_service: cover property (mode == SCSC_IDLE ##1 service_irq);
  c_warm_done: cover property (mode == SCSC_WARMUP ##1 mode == SCSC_NORMAL);
  c_halt_seen: cover property (mode == SCSC_HALT ##1 mode == SCSC_WARMUP);
endmodule // scsc_top_asserts
`default_nettype wire

// *** test/scsc_core_model.sv ***
`default_nettype none
module scsc_core_model (
  input  wire logic pclk,           // clock
  input  wire logic resume_next,    // core resumes
  input  wire logic service_irq,    // core services request
  output logic      wake_pin,       // wake-up pin
  output logic      irq_peripheral, // peripheral request
  output logic      irq_external,   // external request
  output logic      irq_en          // master enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wake_pin = 1'b0;
    irq_peripheral = 1'b0;
    irq_external = 1'b0;
    irq_en = 1'b0;
  end
  task automatic set_wake(input logic v);
    @(posedge pclk);
    wake_pin <= v;
  endtask
  // request stays up until the core reacts, as a latched request would
  task automatic irq(input logic ext, input logic en);
    int n;
    @(posedge pclk);
    irq_en <= en;
    irq_external <= ext;
    irq_peripheral <= !ext;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (resume_next !== 1'b1 && service_irq !== 1'b1 && n < 50);
    irq_external <= 1'b0;
    irq_peripheral <= 1'b0;
  endtask
endmodule // scsc_core_model
`default_nettype wire

// *** test/system_clock_standby_control_tb_top.sv ***
`include "scsc_defines.svh"
`default_nettype none
module system_clock_standby_control_tb_top import scsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W0 = 48;
  localparam int W1 = 16;
  localparam int W2 = 8;
  logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]   paddr = '0;
  logic [31:0]   pwdata = '0, prdata;
  logic          pready, pslverr, wake_pin, irq_peripheral, irq_external, irq_en;
  logic          mcycle_pulse, port_hold, port_hiz, warm_up_active;
  logic          resume_next, service_irq, sys_reset_req;
  scsc_clk_ctl_t clk_ctl;
  scsc_src_clk_t src_clk;
  scsc_mode_t    mode;
  int            error_cnt = 0, checks = 0, n_res = 0, n_srv = 0, n_rst = 0, n_mc = 0, n_tt = 0;
  integer        seed = 32'hb066ff5f;
  always #5 pclk = ~pclk;
  scsc_top #(.WARM_00_CYC(24'(W0)), .WARM_01_CYC(24'(W1)), .WARM_10_CYC(24'(W2))) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .wake_pin(wake_pin), .irq_peripheral(irq_peripheral), .irq_external(irq_external),
    .interrupt_master_enable_flag(irq_en), .clk_ctl(clk_ctl), .src_clk(src_clk),
    .mcycle_pulse(mcycle_pulse), .port_hold(port_hold), .port_hiz(port_hiz),
    .warm_up_active(warm_up_active), .resume_next(resume_next), .service_irq(service_irq),
    .sys_reset_req(sys_reset_req), .mode(mode));
  scsc_core_model u_core (.pclk(pclk), .resume_next(resume_next), .service_irq(service_irq),
    .wake_pin(wake_pin), .irq_peripheral(irq_peripheral), .irq_external(irq_external),
    .irq_en(irq_en));
  always @(posedge pclk) begin
    if (resume_next === 1'b1) n_res++;
    if (service_irq === 1'b1) n_srv++;
    if (sys_reset_req === 1'b1) n_rst++;
    if (mcycle_pulse === 1'b1) n_mc++;
    if (src_clk.timer_tick === 1'b1) n_tt++;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: %s got %h expected %h", $time, s, got, exp);
      error_cnt++;
    end
  endtask
  task automatic chkm(input scsc_mode_t m, input string s);
    chk(32'(mode), 32'(m), s);
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(r, exp, "read data");
    chk({31'h0, e}, {31'h0, xe}, "slave error");
  endtask
  task automatic wait_mode(input scsc_mode_t m, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (mode !== m && n < lim);
    chkm(m, "mode reached");
  endtask
  function automatic int warm(input int c, input int p);
    return (c == 1 ? W1 : c == 2 ? W2 : W0) << p;
  endfunction
  task automatic note(input string s);
    $display("test %s done, mismatches so far %0d", s, error_cnt);
  endtask
  initial begin
    #200000;
    $display("mismatch at %0t: watchdog expired", $time);
    error_cnt++;
    summarize();
  end
  initial begin
    int a, b, n, v;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chkm(SCSC_NORMAL, "mode after reset");
    rd(`SCSC_IDX_STANDBY, 32'h00, 1'b0);
    rd(`SCSC_IDX_SYSCTL2, 32'h80, 1'b0);
    rd(`SCSC_IDX_DIVCTL, 32'h00, 1'b0);
    rd(8'h3f, 32'h00, 1'b1);
    note("reset");
    for (int k = 0; k < 4; k++) begin
      v = $random(seed) & 8'h7f;
      wr(`SCSC_IDX_STANDBY, 8'(v));
      rd(`SCSC_IDX_STANDBY, v & 8'h7c, 1'b0);
      wr(`SCSC_IDX_DIVCTL, 8'(v));
      rd(`SCSC_IDX_DIVCTL, v & 1, 1'b0);
    end
    wr(`SCSC_IDX_STANDBY, 8'h00);
    note("registers");
    for (int p = 0; p < 2; p++) begin
      wr(`SCSC_IDX_DIVCTL, 8'(p));
      @(negedge pclk);
      a = n_mc;
      b = n_tt;
      repeat (1024) @(negedge pclk);
      chk(n_mc - a, 256, "machine cycles");
      chk(n_tt - b, 1024 >> (`SCSC_TAP_TIMER + p), "timer ticks");
    end
    note("timing");
    for (int k = 0; k < 4; k++) begin
      wr(`SCSC_IDX_SYSCTL2, 8'h90);
      wait_mode(SCSC_IDLE, 4);
      rd(`SCSC_IDX_STATUS, 32'h01, 1'b0);
      a = n_srv;
      b = n_res;
      u_core.irq(k[0], k[1]);
      wait_mode(SCSC_NORMAL, 4);
      repeat (2) @(negedge pclk);
      chk(n_srv - a, {31'h0, k[1]}, "service pulses");
      chk(n_res - b, {31'h0, !k[1]}, "resume pulses");
      rd(`SCSC_IDX_SYSCTL2, 32'h80, 1'b0);
    end
    note("idle");
    for (int k = 0; k < 8; k++) begin
      wr(`SCSC_IDX_DIVCTL, 8'(k >> 2));
      v = 8'h90 | ((k & 3) << 2);
      u_core.set_wake(k[0]);
      wr(`SCSC_IDX_STANDBY, 8'(v));
      wait_mode(SCSC_HALT, 4);
      repeat (3 + ($random(seed) & 7)) @(negedge pclk);
      chkm(SCSC_HALT, "halt holds");
      chk({31'h0, port_hold}, 32'h1, "outputs held");
      rd(`SCSC_IDX_STATUS, 32'h02, 1'b0);
      a = n_res;
      u_core.set_wake(1'b0);
      u_core.set_wake(1'b1);
      wait_mode(SCSC_WARMUP, 4);
      chk({31'h0, warm_up_active}, 32'h1, "warm-up flag");
      n = 0;
      while (mode === SCSC_WARMUP && n < 1000) begin
        n++;
        @(negedge pclk);
      end
      chk(n, warm(k & 3, k >> 2), "warm-up cycles");
      chkm(SCSC_NORMAL, "after warm-up");
      rd(`SCSC_IDX_STANDBY, v & 8'h7c, 1'b0);
      chk(n_res - a, 1, "resume after halt");
      u_core.set_wake(1'b0);
    end
    note("edge halt");
    wr(`SCSC_IDX_DIVCTL, 8'h00);
    for (int k = 0; k < 2; k++) begin
      u_core.set_wake(k[0]);
      wr(`SCSC_IDX_STANDBY, 8'hc0);
      repeat (3) @(negedge pclk);
      chkm(k ? SCSC_WARMUP : SCSC_HALT, "level mode entry");
      chk({31'h0, port_hiz}, 32'h1, "outputs float");
      u_core.set_wake(1'b1);
      wait_mode(SCSC_NORMAL, 200);
      u_core.set_wake(1'b0);
    end
    note("level halt");
    // post-wake field set on purpose: reset must ignore it
    wr(`SCSC_IDX_STANDBY, 8'hb0);
    wait_mode(SCSC_HALT, 4);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chkm(SCSC_NORMAL, "reset out of halt");
    rd(`SCSC_IDX_STANDBY, 32'h00, 1'b0);
    note("reset in halt");
    a = n_rst;
    wr(`SCSC_IDX_SYSCTL2, 8'h00);
    repeat (3) @(negedge pclk);
    chk(n_rst - a, 1, "oscillator-off reset");
    note("oscillator off");
    summarize();
  end
endmodule // system_clock_standby_control_tb_top
bind scsc_top scsc_top_asserts #(.WARM_00_CYC(WARM_00_CYC), .WARM_01_CYC(WARM_01_CYC),
  .WARM_10_CYC(WARM_10_CYC)) u_asrt (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .irq_peripheral(irq_peripheral), .irq_external(irq_external),
  .interrupt_master_enable_flag(interrupt_master_enable_flag), .clk_ctl(clk_ctl),
  .src_clk(src_clk), .mcycle_pulse(mcycle_pulse), .port_hold(port_hold),
  .port_hiz(port_hiz), .resume_next(resume_next), .service_irq(service_irq), .mode(mode));
`default_nettype wire
